//--- verilog/tmfl_pkg.sv
// What this block does
// - never send more than max frame length bytes
// - pad every frame up to min frame length or max frame length, whichever is lower
// - record peak collisions of successful frames
// - peak record stays below retry ceiling
// - reading peak record returns it, then zeroes it
// - defer timer counts only while deferring; loadable
// - defer timer ticks every 256 byte periods
// - count every attempt that meets a collision
// - count frames collided once, then succeeded
// - count frames abandoned past retry ceiling
// - late collision abandons frame and is counted
// - attempts per frame limited by retry ceiling
package tmfl_pkg;

    // ----------------------------------------
    // register byte addresses
    // ----------------------------------------
    localparam int          ADDR_W           = 28;
    localparam logic [27:0] OFS_RETRY_CEIL   = 28'h8c06218;
    localparam logic [27:0] OFS_MAX_LEN      = 28'h8c06230;
    localparam logic [27:0] OFS_MIN_LEN      = 28'h8c06234;
    localparam logic [27:0] OFS_PEAK         = 28'h8c06238;
    localparam logic [27:0] OFS_DEFER        = 28'h8c0623c;
    localparam logic [27:0] OFS_NORM_COLL    = 28'h8c06240;
    localparam logic [27:0] OFS_SECOND_TRY   = 28'h8c06244;
    localparam logic [27:0] OFS_EXCESS_COLL  = 28'h8c06248;
    localparam logic [27:0] OFS_LATE_COLL    = 28'h8c0624c;

    // ----------------------------------------
    // field widths (all fields start at bit 0)
    // ----------------------------------------
    localparam int FLD_LSB = 0;
    localparam int W_BYTE  = 8;
    localparam int W_HALF  = 16;

    // ----------------------------------------
    // reset values
    // ----------------------------------------
    localparam logic [7:0]  RST_RETRY_CEIL = 8'h10;
    localparam logic [15:0] RST_MAX_LEN    = 16'h05ee;
    localparam logic [7:0]  RST_MIN_LEN    = 8'h40;
    localparam logic [7:0]  RST_PEAK       = 8'h00;
    localparam logic [15:0] RST_CNT        = 16'h0000;

    // ----------------------------------------
    // timing: defer prescaler spans 256 byte periods
    // ----------------------------------------
    localparam logic [7:0] DEFER_PRESC_LAST = 8'hff;

    // ----------------------------------------
    // register select positions
    // ----------------------------------------
    localparam int SEL_RETRY  = 0;
    localparam int SEL_MAX    = 1;
    localparam int SEL_MIN    = 2;
    localparam int SEL_PEAK   = 3;
    localparam int SEL_DEFER  = 4;
    localparam int SEL_NORM   = 5;
    localparam int SEL_SECOND = 6;
    localparam int SEL_EXCESS = 7;
    localparam int SEL_LATE   = 8;
    localparam int SEL_N      = 9;

    // transmit sequencer states
    typedef enum logic [2:0] {
        ST_IDLE  = 3'h1,
        ST_DEFER = 3'h2,
        ST_SEND  = 3'h4
    } tmfl_state_t;

endpackage

//--- verilog/tmfl_cnt_if.sv
// loadable counter hookup: load, increment and current value
interface tmfl_cnt_if #(parameter int W = 16);
    logic         ld;
    logic [W-1:0] ld_val;
    logic         inc;
    logic [W-1:0] val;

    modport ctl (output ld, output ld_val, output inc, input val);
    modport cnt (input ld, input ld_val, input inc, output val);
endinterface

//--- verilog/tmfl_stat_cnt.sv
module tmfl_stat_cnt #(
    parameter int W = 16
) (
    input wire logic   clk_sys,
    input wire logic   nrst,
    tmfl_cnt_if.cnt    port
);

    typedef struct packed {
        logic [W-1:0] val;
    } tmfl_cnt_st_t;

    tmfl_cnt_st_t q;
    tmfl_cnt_st_t d;

    // load and count in one cycle: the event is kept on top of the load
    // wraps past ones
    always_comb begin
        d = q;
        if (port.ld) begin
            d.val = port.ld_val;
        end
        if (port.inc) begin
            d.val = W'(d.val + W'(1));
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            q.val <= tmfl_pkg::RST_CNT[W-1:0];
        end else begin
            q <= d;
        end
    end

    assign port.val = q.val;

    a_cnt_wrap : assert property (@(posedge clk_sys) disable iff (!nrst)
        (port.inc && !port.ld && (&q.val)) |=> (q.val == '0))
        else $error("counter did not wrap to zero");

    a_cnt_step : assert property (@(posedge clk_sys) disable iff (!nrst)
        (port.inc && !port.ld) |=> (q.val == W'($past(q.val) + W'(1))))
        else $error("counter missed an increment");

endmodule

//--- verilog/tmfl_top.sv
module tmfl_top (
    input  wire logic        clk_sys,
    input  wire logic        nrst,
    input  wire logic [27:0] reg_addr,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic [31:0] reg_wdata,
    output logic      [31:0] reg_rdata,
    output logic             reg_rvalid,
    input  wire logic        tx_req,
    input  wire logic        tx_data_valid,
    input  wire logic        tx_data_last,
    input  wire logic        byte_tick,
    input  wire logic        col_pin,
    input  wire logic        crs_pin,
    output logic             tx_en,
    output logic             tx_pad,
    output logic             tx_data_take,
    output logic             tx_done,
    output logic             tx_abort,
    output logic             tx_restart
);

    // ----------------------------------------
    // state
    // ----------------------------------------
    typedef struct packed {
        tmfl_pkg::tmfl_state_t st;
        logic        col_s1;
        logic        col_s2;
        logic        crs_s1;
        logic        crs_s2;
        logic [7:0]  retry_ceil;
        logic [15:0] max_len;
        logic [7:0]  min_len;
        logic [7:0]  peak;
        logic [15:0] byte_cnt;
        logic [7:0]  attempts;
        logic        data_done;
        logic [7:0]  presc;
        logic [31:0] rdata;
        logic        rvalid;
        logic        tx_en;
        logic        tx_pad;
        logic        data_take;
        logic        done;
        logic        abort;
        logic        restart;
    } tmfl_st_t;

    tmfl_st_t    q;
    tmfl_st_t    d;
    logic [8:0]  wr_sel;
    logic [8:0]  rd_sel;
    logic        ev_defer;
    logic        ev_norm;
    logic        ev_second;
    logic        ev_excess;
    logic        ev_late;
    logic        fin_ok;
    logic [7:0]  coll_n;
    logic [7:0]  coll_cap;
    logic [7:0]  peak_base;

    // ----------------------------------------
    // address decode
    // ----------------------------------------
    function automatic logic [8:0] tmfl_sel(input logic [27:0] a);
        logic [8:0] s;
        s = 9'h000;
        if (a == tmfl_pkg::OFS_RETRY_CEIL) begin
            s[tmfl_pkg::SEL_RETRY] = 1'b1;
        end else if (a == tmfl_pkg::OFS_MAX_LEN) begin
            s[tmfl_pkg::SEL_MAX] = 1'b1;
        end else if (a == tmfl_pkg::OFS_MIN_LEN) begin
            s[tmfl_pkg::SEL_MIN] = 1'b1;
        end else if (a == tmfl_pkg::OFS_PEAK) begin
            s[tmfl_pkg::SEL_PEAK] = 1'b1;
        end else if (a == tmfl_pkg::OFS_DEFER) begin
            s[tmfl_pkg::SEL_DEFER] = 1'b1;
        end else if (a == tmfl_pkg::OFS_NORM_COLL) begin
            s[tmfl_pkg::SEL_NORM] = 1'b1;
        end else if (a == tmfl_pkg::OFS_SECOND_TRY) begin
            s[tmfl_pkg::SEL_SECOND] = 1'b1;
        end else if (a == tmfl_pkg::OFS_EXCESS_COLL) begin
            s[tmfl_pkg::SEL_EXCESS] = 1'b1;
        end else if (a == tmfl_pkg::OFS_LATE_COLL) begin
            s[tmfl_pkg::SEL_LATE] = 1'b1;
        end
        return s;
    endfunction

    assign wr_sel = reg_wr ? tmfl_sel(reg_addr) : 9'h000;
    assign rd_sel = reg_rd ? tmfl_sel(reg_addr) : 9'h000;

    // ----------------------------------------
    // statistics counters
    // ----------------------------------------
    tmfl_cnt_if #(.W(16)) dtmr_if ();
    tmfl_cnt_if #(.W(16)) norm_if ();
    tmfl_cnt_if #(.W(16)) second_if ();
    tmfl_cnt_if #(.W(8))  excess_if ();
    tmfl_cnt_if #(.W(8))  late_if ();

    tmfl_stat_cnt #(.W(16)) u_defer  (.clk_sys(clk_sys), .nrst(nrst), .port(dtmr_if));
    tmfl_stat_cnt #(.W(16)) u_norm   (.clk_sys(clk_sys), .nrst(nrst), .port(norm_if));
    tmfl_stat_cnt #(.W(16)) u_second (.clk_sys(clk_sys), .nrst(nrst), .port(second_if));
    tmfl_stat_cnt #(.W(8))  u_excess (.clk_sys(clk_sys), .nrst(nrst), .port(excess_if));
    tmfl_stat_cnt #(.W(8))  u_late   (.clk_sys(clk_sys), .nrst(nrst), .port(late_if));

    // software loads and hardware events into the counters
    assign dtmr_if.ld     = wr_sel[tmfl_pkg::SEL_DEFER];
    assign dtmr_if.ld_val = reg_wdata[15:0];
    assign dtmr_if.inc    = ev_defer;
    assign norm_if.ld     = wr_sel[tmfl_pkg::SEL_NORM];
    assign norm_if.ld_val = reg_wdata[15:0];
    assign norm_if.inc    = ev_norm;
    assign second_if.ld     = wr_sel[tmfl_pkg::SEL_SECOND];
    assign second_if.ld_val = reg_wdata[15:0];
    assign second_if.inc    = ev_second;
    assign excess_if.ld     = wr_sel[tmfl_pkg::SEL_EXCESS];
    assign excess_if.ld_val = reg_wdata[7:0];
    assign excess_if.inc    = ev_excess;
    assign late_if.ld     = wr_sel[tmfl_pkg::SEL_LATE];
    assign late_if.ld_val = reg_wdata[7:0];
    assign late_if.inc    = ev_late;

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        d         = q;
        ev_defer  = 1'b0;
        ev_norm   = 1'b0;
        ev_second = 1'b0;
        ev_excess = 1'b0;
        ev_late   = 1'b0;
        fin_ok    = 1'b0;
        // pins cross in; only the second flop is looked at
        d.col_s1    = col_pin;
        d.col_s2    = q.col_s1;
        d.crs_s1    = crs_pin;
        d.crs_s2    = q.crs_s1;
        d.data_take = 1'b0;
        d.done      = 1'b0;
        d.abort     = 1'b0;
        d.restart   = 1'b0;
        if (byte_tick) begin
            d.presc = 8'(q.presc + 8'h01);
        end
        coll_n   = 8'(q.attempts - 8'h01);
        coll_cap = (q.retry_ceil == 8'h00) ? 8'h00 : 8'(q.retry_ceil - 8'h01);
        case (q.st)
            tmfl_pkg::ST_IDLE: begin
                d.tx_en    = 1'b0;
                d.tx_pad   = 1'b0;
                d.attempts = 8'h00;
                if (tx_req) begin
                    d.st = tmfl_pkg::ST_DEFER;
                end
            end
            tmfl_pkg::ST_DEFER: begin
                // timer runs only while held off by traffic
                if (q.crs_s2) begin
                    ev_defer = byte_tick && (q.presc == tmfl_pkg::DEFER_PRESC_LAST);
                end else if (byte_tick) begin
                    d.st        = tmfl_pkg::ST_SEND;
                    d.attempts  = 8'(q.attempts + 8'h01);
                    d.byte_cnt  = 16'h0000;
                    d.data_done = 1'b0;
                end
            end
            tmfl_pkg::ST_SEND: begin
                if (q.col_s2) begin
                    ev_norm  = 1'b1;
                    d.tx_en  = 1'b0;
                    d.tx_pad = 1'b0;
                    d.st     = tmfl_pkg::ST_IDLE;
                    if (q.byte_cnt >= {8'h00, q.min_len}) begin
                        // late collision gives the frame up
                        ev_late = 1'b1;
                        d.abort = 1'b1;
                    end else if (q.attempts >= q.retry_ceil) begin
                        ev_excess = 1'b1;
                        d.abort   = 1'b1;
                    end else begin
                        d.restart = 1'b1;
                        d.st      = tmfl_pkg::ST_DEFER;
                    end
                end else if (byte_tick) begin
                    d.tx_en  = 1'b0;
                    d.tx_pad = 1'b0;
                    if (q.byte_cnt >= q.max_len) begin
                        fin_ok = 1'b1;
                    end else if (!q.data_done && tx_data_valid) begin
                        d.tx_en     = 1'b1;
                        d.data_take = 1'b1;
                        d.data_done = tx_data_last;
                        d.byte_cnt  = 16'(q.byte_cnt + 16'h0001);
                    end else if (q.data_done && (q.byte_cnt < {8'h00, q.min_len})) begin
                        d.tx_en    = 1'b1;
                        d.tx_pad   = 1'b1;
                        d.byte_cnt = 16'(q.byte_cnt + 16'h0001);
                    end else if (q.data_done) begin
                        fin_ok = 1'b1;
                    end
                    if (fin_ok) begin
                        d.done = 1'b1;
                        d.st   = tmfl_pkg::ST_IDLE;
                        ev_second = (q.attempts == 8'h02);
                    end
                end
            end
            default: begin
                d.st = tmfl_pkg::ST_IDLE;
            end
        endcase
        // read clears, a same-cycle update still lands
        peak_base = rd_sel[tmfl_pkg::SEL_PEAK] ? tmfl_pkg::RST_PEAK : q.peak;
        d.peak    = peak_base;
        if (fin_ok) begin
            if (((coll_n < coll_cap) ? coll_n : coll_cap) > peak_base) begin
                d.peak = (coll_n < coll_cap) ? coll_n : coll_cap;
            end
        end
        // software writes to configuration
        if (wr_sel[tmfl_pkg::SEL_RETRY]) begin
            d.retry_ceil = reg_wdata[7:0];
        end
        if (wr_sel[tmfl_pkg::SEL_MAX]) begin
            d.max_len = reg_wdata[15:0];
        end
        if (wr_sel[tmfl_pkg::SEL_MIN]) begin
            d.min_len = reg_wdata[7:0];
        end
        // read data, zero for unmapped addresses
        d.rvalid = reg_rd;
        d.rdata  = 32'h0000_0000;
        if (rd_sel[tmfl_pkg::SEL_RETRY]) begin
            d.rdata = {24'h000000, q.retry_ceil};
        end else if (rd_sel[tmfl_pkg::SEL_MAX]) begin
            d.rdata = {16'h0000, q.max_len};
        end else if (rd_sel[tmfl_pkg::SEL_MIN]) begin
            d.rdata = {24'h000000, q.min_len};
        end else if (rd_sel[tmfl_pkg::SEL_PEAK]) begin
            d.rdata = {24'h000000, q.peak};
        end else if (rd_sel[tmfl_pkg::SEL_DEFER]) begin
            d.rdata = {16'h0000, dtmr_if.val};
        end else if (rd_sel[tmfl_pkg::SEL_NORM]) begin
            d.rdata = {16'h0000, norm_if.val};
        end else if (rd_sel[tmfl_pkg::SEL_SECOND]) begin
            d.rdata = {16'h0000, second_if.val};
        end else if (rd_sel[tmfl_pkg::SEL_EXCESS]) begin
            d.rdata = {24'h000000, excess_if.val};
        end else if (rd_sel[tmfl_pkg::SEL_LATE]) begin
            d.rdata = {24'h000000, late_if.val};
        end
    end

    // state register
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            q            <= '0;
            q.st         <= tmfl_pkg::ST_IDLE;
            q.retry_ceil <= tmfl_pkg::RST_RETRY_CEIL;
            q.max_len    <= tmfl_pkg::RST_MAX_LEN;
            q.min_len    <= tmfl_pkg::RST_MIN_LEN;
            q.peak       <= tmfl_pkg::RST_PEAK;
        end else begin
            q <= d;
        end
    end

    // outputs straight from flops
    assign reg_rdata    = q.rdata;
    assign reg_rvalid   = q.rvalid;
    assign tx_en        = q.tx_en;
    assign tx_pad       = q.tx_pad;
    assign tx_data_take = q.data_take;
    assign tx_done      = q.done;
    assign tx_abort     = q.abort;
    assign tx_restart   = q.restart;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);

    sequence s_late_col;
        (q.st == tmfl_pkg::ST_SEND) && q.col_s2 && (q.byte_cnt >= {8'h00, q.min_len});
    endsequence

    sequence s_retry_col;
        (q.st == tmfl_pkg::ST_SEND) && q.col_s2 && (q.byte_cnt < {8'h00, q.min_len})
            && (q.attempts < q.retry_ceil);
    endsequence

    a_max_len_cap : assert property (
        q.data_take |-> (q.byte_cnt <= $past(q.max_len)))
        else $error("frame grew past max length");

    a_min_len_pad : assert property (
        q.done |-> ((q.byte_cnt >= {8'h00, $past(q.min_len)}) || (q.byte_cnt >= $past(q.max_len))))
        else $error("frame ended short of min length");

    a_peak_bound : assert property (
        (q.peak != $past(q.peak)) && (q.peak != 8'h00) |-> (q.peak < $past(q.retry_ceil)))
        else $error("peak record reached retry ceiling");

    a_peak_clear : assert property (
        (rd_sel[tmfl_pkg::SEL_PEAK] && !fin_ok) |=> (q.peak == 8'h00) && (reg_rdata == {24'h000000, $past(q.peak)}))
        else $error("peak record read did not clear");

    a_defer_tick : assert property (
        ev_defer |-> (q.st == tmfl_pkg::ST_DEFER) && q.crs_s2 ##1 (q.presc == 8'h00))
        else $error("defer timer ticked off the 256 period");

    a_late_abort : assert property (
        s_late_col |=> q.abort && (q.st == tmfl_pkg::ST_IDLE) && !q.restart)
        else $error("late collision did not abandon frame");

    a_retry_restart : assert property (
        s_retry_col |=> q.restart && (q.st == tmfl_pkg::ST_DEFER) && !q.tx_en)
        else $error("early collision did not retry");

    a_attempt_limit : assert property (
        (q.st == tmfl_pkg::ST_SEND) && $stable(q.retry_ceil) && (q.retry_ceil != 8'h00)
            |-> (q.attempts <= q.retry_ceil))
        else $error("attempts exceeded retry ceiling");

    a_idle_quiet : assert property (
        (q.st == tmfl_pkg::ST_SEND) && q.col_s2 |-> ev_norm ##1 !q.tx_en)
        else $error("collision not counted or line left driven");

endmodule

//--- tb/tmfl_medium_model.sv
// medium seen through the transceiver: byte pacing, carrier, collisions
module tmfl_medium_model #(
    parameter int TICK_DIV = 8
) (
    input  wire logic       clk_sys,
    input  wire logic       nrst,
    input  wire logic       tx_en,
    input  wire logic       net_busy,
    input  wire logic [7:0] col_at,
    input  wire logic [7:0] col_num,
    input  wire logic       col_arm,
    output logic            byte_tick,
    output logic            crs_pin,
    output logic            col_pin
);
    timeunit 1ns;
    timeprecision 100ps;

    int         div_q    = 0;
    logic [7:0] nbytes_q = 8'h00;
    logic [7:0] left_q   = 8'h00;

    // one tick per byte period; a collision hits the armed byte of an attempt
    always @(posedge clk_sys) begin
        if (!nrst) begin
            div_q <= 0;
            byte_tick <= 1'b0;
            crs_pin <= 1'b0;
            col_pin <= 1'b0;
            left_q <= 8'h00;
            nbytes_q <= 8'h00;
        end else begin
            div_q <= (div_q == TICK_DIV - 1) ? 0 : div_q + 1;
            byte_tick <= (div_q == TICK_DIV - 1);
            crs_pin <= net_busy;
            col_pin <= 1'b0;
            if (col_arm) begin
                left_q <= col_num;
            end else if (byte_tick) begin
                // idle byte periods restart the per-attempt byte count
                if (!tx_en) begin
                    nbytes_q <= 8'h00;
                end else if (left_q != 8'h00 && nbytes_q + 8'h01 == col_at) begin
                    col_pin <= 1'b1;
                    left_q <= left_q - 8'h01;
                    nbytes_q <= 8'h00;
                end else begin
                    nbytes_q <= nbytes_q + 8'h01;
                end
            end
        end
    end
endmodule

//--- tb/tmfl_testbench.sv
module testbench;
    timeunit 1ns;
    timeprecision 100ps;

    // ----------------------------------------
    // signals
    // ----------------------------------------
    logic        clk_sys       = 1'b0;
    logic        nrst          = 1'b0;
    logic [27:0] reg_addr      = 28'h0000000;
    logic        reg_wr        = 1'b0;
    logic        reg_rd        = 1'b0;
    logic [31:0] reg_wdata     = 32'h00000000;
    logic [31:0] reg_rdata;
    logic        reg_rvalid;
    logic        tx_req        = 1'b0;
    logic        tx_data_valid = 1'b0;
    logic        tx_data_last  = 1'b0;
    logic        pend          = 1'b0;
    logic        byte_tick;
    logic        col_pin;
    logic        crs_pin;
    logic        tx_en;
    logic        tx_pad;
    logic        tx_data_take;
    logic        tx_done;
    logic        tx_abort;
    logic        tx_restart;
    logic        net_busy      = 1'b0;
    logic [7:0]  col_at        = 8'h00;
    logic [7:0]  col_num       = 8'h00;
    logic        col_arm       = 1'b0;
    int          frame_len     = 1;
    int          takes         = 0;
    int          nxt;
    int          byte_cnt      = 0;
    int          pad_cnt       = 0;
    int          frame_bytes   = 0;
    int          frame_pad     = 0;
    int          n_restart     = 0;
    int          cycles        = 0;
    int          num_errors    = 0;
    int          n_compared    = 0;
    logic        ab;
    logic [31:0] rd;
    int          r0;

    // register map order: ceiling, max, min, peak, defer, normal, second, excess, late
    localparam logic [27:0] ADR [9] = '{tmfl_pkg::OFS_RETRY_CEIL, tmfl_pkg::OFS_MAX_LEN,
        tmfl_pkg::OFS_MIN_LEN, tmfl_pkg::OFS_PEAK, tmfl_pkg::OFS_DEFER,
        tmfl_pkg::OFS_NORM_COLL, tmfl_pkg::OFS_SECOND_TRY, tmfl_pkg::OFS_EXCESS_COLL,
        tmfl_pkg::OFS_LATE_COLL};
    localparam logic [31:0] RST [9] = '{32'h10, 32'h5ee, 32'h40, 32'h0, 32'h0, 32'h0,
        32'h0, 32'h0, 32'h0};
    localparam logic [31:0] MSK [9] = '{32'hff, 32'hffff, 32'hff, 32'h0, 32'hffff,
        32'hffff, 32'hffff, 32'hff, 32'hff};
    localparam logic [27:0] UNMAPPED = 28'h8c06250;

    always #2.5 clk_sys = ~clk_sys;

    tmfl_top tmfl_top_inst (.clk_sys(clk_sys), .nrst(nrst), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .tx_req(tx_req), .tx_data_valid(tx_data_valid),
        .tx_data_last(tx_data_last), .byte_tick(byte_tick), .col_pin(col_pin),
        .crs_pin(crs_pin), .tx_en(tx_en), .tx_pad(tx_pad), .tx_data_take(tx_data_take),
        .tx_done(tx_done), .tx_abort(tx_abort), .tx_restart(tx_restart));

    tmfl_medium_model #(.TICK_DIV(8)) tmfl_medium_model_inst (.clk_sys(clk_sys),
        .nrst(nrst), .tx_en(tx_en), .net_busy(net_busy), .col_at(col_at),
        .col_num(col_num), .col_arm(col_arm), .byte_tick(byte_tick), .crs_pin(crs_pin),
        .col_pin(col_pin));

    // ----------------------------------------
    // frame source and wire monitor
    // ----------------------------------------
    // last flag is computed ahead so it stands with the byte it marks
    always @(posedge clk_sys) begin
        nxt = (!pend || tx_restart) ? 0 : takes + (tx_data_take ? 1 : 0);
        takes <= nxt;
        tx_data_valid <= pend;
        tx_data_last <= pend && (nxt == frame_len - 1);
        if (tx_restart) begin
            byte_cnt <= 0;
            pad_cnt <= 0;
            n_restart <= n_restart + 1;
        end else if (tx_done || tx_abort) begin
            frame_bytes <= byte_cnt;
            frame_pad <= pad_cnt;
            byte_cnt <= 0;
            pad_cnt <= 0;
        end else if (byte_tick && tx_en) begin
            byte_cnt <= byte_cnt + 1;
            pad_cnt <= pad_cnt + (tx_pad ? 1 : 0);
        end
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            num_errors = num_errors + 1;
            end_of_test();
        end
    end

    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_compared = n_compared + 1;
        if (got !== exp) begin
            num_errors = num_errors + 1;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [27:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask

    // answer stands for one cycle after the strobe edge
    task automatic rd_chk(input logic [27:0] a, input logic [31:0] exp);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        check((reg_rvalid === 1'b1) ? reg_rdata : 32'hxxxxxxxx, exp);
    endtask

    task automatic arm(input logic [7:0] n, input logic [7:0] at);
        @(posedge clk_sys);
        col_num <= n;
        col_at <= at;
        col_arm <= 1'b1;
        @(posedge clk_sys);
        col_arm <= 1'b0;
    endtask

    // request is one cycle: a level still high in the idle cycle after
    // done would start a second, empty frame
    task automatic start_frame(input int len);
        @(posedge clk_sys);
        frame_len <= len;
        tx_req <= 1'b1;
        pend <= 1'b1;
        @(posedge clk_sys);
        tx_req <= 1'b0;
    endtask

    // bounded wait; the cycle ceiling catches a frame that never ends
    task automatic wait_frame(output logic aborted);
        int i;
        for (i = 0; i < 20000 && tx_done !== 1'b1 && tx_abort !== 1'b1; i++) begin
            @(posedge clk_sys);
            #1;
        end
        aborted = tx_abort;
        if (tx_done !== 1'b1 && tx_abort !== 1'b1) begin
            num_errors = num_errors + 1;
        end
        @(posedge clk_sys);
        pend <= 1'b0;
        repeat (2) @(posedge clk_sys);
        #1;
    endtask

    task automatic end_of_test;
        $display("compared %0d, errors %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // ----------------------------------------
    // test sequence
    // ----------------------------------------
    initial begin
        repeat (4) @(posedge clk_sys);
        nrst <= 1'b1;
        // reset values, field widths, read-only record, unmapped place
        for (int i = 0; i < 9; i++) rd_chk(ADR[i], RST[i]);
        for (int i = 0; i < 9; i++) begin
            wr(ADR[i], 32'hffffffff);
            rd_chk(ADR[i], MSK[i]);
        end
        for (int i = 0; i < 9; i++) wr(ADR[i], RST[i]);
        wr(UNMAPPED, 32'hffffffff);
        rd_chk(UNMAPPED, 32'h0);
        // short frame is padded out to the minimum
        start_frame(10);
        wait_frame(ab);
        check(frame_bytes, 32'd64);
        check(frame_pad, 32'd54);
        // long frame is cut at the maximum
        wr(tmfl_pkg::OFS_MAX_LEN, 32'd20);
        start_frame(100);
        wait_frame(ab);
        check(frame_bytes, 32'd20);
        wr(tmfl_pkg::OFS_MAX_LEN, 32'h5ee);
        // early collision then success on the second try
        wr(tmfl_pkg::OFS_NORM_COLL, 32'hffff);
        arm(8'd1, 8'd5);
        start_frame(10);
        wait_frame(ab);
        check(frame_bytes, 32'd64);
        rd_chk(tmfl_pkg::OFS_NORM_COLL, 32'h0);
        rd_chk(tmfl_pkg::OFS_SECOND_TRY, 32'h1);
        rd_chk(tmfl_pkg::OFS_PEAK, 32'h1);
        rd_chk(tmfl_pkg::OFS_PEAK, 32'h0);
        // collision past the minimum abandons the frame
        arm(8'd1, 8'd70);
        start_frame(80);
        wait_frame(ab);
        check({31'h0, ab}, 32'h1);
        rd_chk(tmfl_pkg::OFS_LATE_COLL, 32'h1);
        rd_chk(tmfl_pkg::OFS_NORM_COLL, 32'h1);
        rd_chk(tmfl_pkg::OFS_PEAK, 32'h0);
        // every attempt collides until the ceiling gives the frame up
        wr(tmfl_pkg::OFS_RETRY_CEIL, 32'h3);
        wr(tmfl_pkg::OFS_EXCESS_COLL, 32'hff);
        r0 = n_restart;
        arm(8'd3, 8'd2);
        start_frame(10);
        wait_frame(ab);
        check({31'h0, ab}, 32'h1);
        check(n_restart - r0, 32'd2);
        rd_chk(tmfl_pkg::OFS_EXCESS_COLL, 32'h0);
        rd_chk(tmfl_pkg::OFS_NORM_COLL, 32'h4);
        wr(tmfl_pkg::OFS_RETRY_CEIL, 32'h10);
        // busy network for 768 byte periods: three prescaler wraps
        wr(tmfl_pkg::OFS_DEFER, 32'hfffe);
        @(posedge clk_sys);
        net_busy <= 1'b1;
        // carrier must be through the synchroniser before the request
        repeat (2) @(posedge clk_sys);
        start_frame(10);
        // 6144 deferring edges: exactly 768 byte ticks
        repeat (6141) @(posedge clk_sys);
        net_busy <= 1'b0;
        wait_frame(ab);
        check(frame_bytes, 32'd64);
        rd_chk(tmfl_pkg::OFS_DEFER, 32'h1);
        end_of_test();
    end
endmodule
